// ### verif/tb.sv
// Self-checking bench for the watchdog and address trap
`timescale 1ns/1ps
`default_nettype none
`include "wdat_map.svh"
module tb;
  localparam logic [11:0] CTL = `WDAT_OFF_CTRL_ONE;
  localparam logic [11:0] CMD = `WDAT_OFF_COMMAND;
  localparam logic [11:0] STS = `WDAT_OFF_STATUS;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [11:0] paddr;
  logic        psel, penable, pwrite, pready, pslverr;
  logic [31:0] pwdata, prdata;
  logic        fv, pause, lsm, wd_irq, trap_irq, rst_req, pin_n, osc;
  logic [15:0] fa;
  logic [3:0]  ev;
  int          fail_count = 0;
  int          num_checks = 0;
  int          cyc = 0;
  int          ev_cnt [4];
  int          last_t, prev_t, low_run, low_len;

  always #25 clk = ~clk;
  assign ev = {osc, rst_req, trap_irq, wd_irq};

  wdat_top #(.DIV_W(7)) wdat_top_i (
    .clk_i(clk), .rst_n_i(rst_n), .paddr_i(paddr), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .fetch_valid_i(fv), .fetch_addr_i(fa), .power_pause_i(pause), .low_speed_mode_one_i(lsm),
    .wd_overflow_irq_o(wd_irq), .fetch_trap_irq_o(trap_irq), .sys_reset_req_o(rst_req),
    .reset_pin_n_o(pin_n), .osc_restart_o(osc));

  wdat_cpu_model wdat_cpu_model_i (
    .clk_i(clk), .paddr_o(paddr), .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite),
    .pwdata_o(pwdata), .prdata_i(prdata), .pready_i(pready), .pslverr_i(pslverr),
    .fetch_valid_o(fv), .fetch_addr_o(fa), .pause_o(pause), .low_speed_o(lsm));

  // Event counters, overflow spacing and reset pin low time
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 10000) begin
      fail_count++;
      summarize();
    end
    for (int i = 0; i < 4; i++) if (ev[i] === 1'b1) ev_cnt[i] <= ev_cnt[i] + 1;
    if (wd_irq === 1'b1) begin
      prev_t <= last_t;
      last_t <= cyc;
    end
    if (pin_n === 1'b0) low_run <= low_run + 1;
    else if (low_run != 0) begin
      low_len <= low_run;
      low_run <= 0;
    end
  end

  task automatic summarize;
    if (fail_count == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic do_reset;
    rst_n <= 1'b0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] rd;
    logic        err;
    wdat_cpu_model_i.apb(a, 1'b1, {24'h0, d}, rd, err);
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic [31:0] m, input logic eexp);
    logic [31:0] rd;
    logic        err;
    wdat_cpu_model_i.apb(a, 1'b0, 32'h0, rd, err);
    check(rd & m, exp);
    check({31'h0, err}, {31'h0, eexp});
  endtask

  // Wait up to lim cycles for n more events of kind i
  task automatic wait_ev(input int i, input int n, input int lim);
    int base;
    base = ev_cnt[i];
    for (int k = 0; k < lim && ev_cnt[i] < base + n; k++) @(posedge clk);
    check(ev_cnt[i] - base, n);
  endtask

  task automatic count(input int i, input int cycles, input int n);
    int base;
    base = ev_cnt[i];
    repeat (cycles) @(posedge clk);
    check(ev_cnt[i] - base, n);
  endtask

  task automatic trap_chk(input int i, input logic [15:0] a, input int n, input logic l, input int exp);
    int base;
    base = ev_cnt[i];
    wdat_cpu_model_i.fetch(a, n, l);
    repeat (3) @(posedge clk);
    check(ev_cnt[i] - base, exp);
  endtask

  initial begin
    int t_clr;
    do_reset();
    rd_chk(STS, 32'h69, 32'h7F, 1'b0);
    rd_chk(12'h00C, 32'h0, 32'hFFFFFFFF, 1'b1);
    // Watchdog reset at the shortest period
    wr(CTL, 8'h3F);
    wait_ev(2, 1, 40);
    wait_ev(2, 1, 60);
    check(low_len, 24);
    check(ev_cnt[3], 0);
    do_reset();
    // Interrupt action, every period code
    for (int c = 3; c >= 0; c--) begin
      wr(CTL, {5'b00111, 2'(c), 1'b0});
      wait_ev(0, 3, 4 << (9 - 2 * c));
      check(last_t - prev_t, 1 << (9 - 2 * c));
    end
    wr(CTL, 8'h3B);
    rd_chk(STS, 32'h49, 32'h79, 1'b0);
    // Regular clearing keeps the overflow away
    repeat (8) begin
      wr(CMD, `WDAT_CODE_CLEAR);
      t_clr = cyc;
      count(0, 40, 0);
    end
    wait_ev(0, 1, 140);
    check({31'h0, last_t - t_clr >= 94}, 32'h1);
    // Pause freezes the count
    wr(CTL, 8'h3E);
    wait_ev(0, 1, 20);
    wdat_cpu_model_i.set_pause(1'b1);
    count(0, 60, 0);
    wdat_cpu_model_i.set_pause(1'b0);
    wait_ev(0, 1, 12);
    // Disable code ignored while enabled, then the proper order
    wr(CMD, `WDAT_CODE_DISABLE);
    rd_chk(STS, 32'h49, 32'h79, 1'b0);
    wdat_cpu_model_i.disable_wd(8'h36);
    rd_chk(STS, 32'h48, 32'h7F, 1'b0);
    count(0, 100, 0);
    // Address trap, interrupt action
    wr(CTL, 8'h26);
    trap_chk(1, 16'h0010, 3, 1'b0, 3);
    trap_chk(1, 16'h0040, 1, 1'b0, 1);
    trap_chk(1, 16'h083F, 1, 1'b0, 1);
    trap_chk(1, 16'h0840, 1, 1'b0, 0);
    wr(CTL, 8'h06);
    trap_chk(1, 16'h0100, 1, 1'b0, 1);
    wr(CMD, `WDAT_CODE_RAM_COMMIT);
    rd_chk(STS, 32'h00, 32'h7F, 1'b0);
    trap_chk(1, 16'h0100, 1, 1'b0, 0);
    trap_chk(1, 16'h003F, 1, 1'b0, 1);
    // Trap reset in low-speed mode one
    wr(CTL, 8'h16);
    trap_chk(2, 16'h0010, 1, 1'b1, 1);
    check(ev_cnt[3], 1);
    repeat (30) @(posedge clk);
    check(low_len, 24);
    summarize();
  end
endmodule // tb
`default_nettype wire

// ### verif/wdat_cpu_model.sv
// Core-side model: APB master, instruction fetches and power state
`timescale 1ns/1ps
`default_nettype none
`include "wdat_map.svh"
module wdat_cpu_model (
  // Clock
  input  wire logic        clk_i,
  // APB master
  output var logic  [11:0] paddr_o,
  output var logic         psel_o,
  output var logic         penable_o,
  output var logic         pwrite_o,
  output var logic  [31:0] pwdata_o,
  input  wire logic [31:0] prdata_i,
  input  wire logic        pready_i,
  input  wire logic        pslverr_i,
  // Core state
  output var logic         fetch_valid_o,
  output var logic  [15:0] fetch_addr_o,
  output var logic         pause_o,
  output var logic         low_speed_o
);
  initial begin
    paddr_o       = 12'hFFF;
    psel_o        = 1'b0;
    penable_o     = 1'b0;
    pwrite_o      = 1'b0;
    pwdata_o      = 32'hFFFFFFFF;
    fetch_valid_o = 1'b0;
    fetch_addr_o  = 16'hFFFF;
    pause_o       = 1'b0;
    low_speed_o   = 1'b0;
  end

  // One transfer; request held until pready seen high
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    @(posedge clk_i);
    psel_o    <= 1'b1;
    penable_o <= 1'b0;
    paddr_o   <= a;
    pwrite_o  <= w;
    pwdata_o  <= d;
    @(posedge clk_i);
    penable_o <= 1'b1;
    do @(posedge clk_i); while (pready_i !== 1'b1);
    rd = prdata_i;
    err = pslverr_i;
    psel_o    <= 1'b0;
    penable_o <= 1'b0;
    paddr_o   <= ~a;
    pwdata_o  <= ~d;
  endtask

  // Mask flag already off in the core; then clear, enable off, disable code
  task automatic disable_wd(input logic [7:0] ctrl);
    logic [31:0] rd;
    logic        err;
    apb(`WDAT_OFF_COMMAND, 1'b1, {24'h0, `WDAT_CODE_CLEAR}, rd, err);
    apb(`WDAT_OFF_CTRL_ONE, 1'b1, {24'h0, ctrl & 8'hF7}, rd, err);
    apb(`WDAT_OFF_COMMAND, 1'b1, {24'h0, `WDAT_CODE_DISABLE}, rd, err);
  endtask

  // Fetch n consecutive cycles from one address
  task automatic fetch(input logic [15:0] a, input int n, input logic lsm);
    @(posedge clk_i);
    fetch_valid_o <= 1'b1;
    fetch_addr_o  <= a;
    low_speed_o   <= lsm;
    repeat (n) @(posedge clk_i);
    fetch_valid_o <= 1'b0;
    fetch_addr_o  <= ~a;
  endtask

  task automatic set_pause(input logic v);
    @(posedge clk_i);
    pause_o <= v;
  endtask
endmodule // wdat_cpu_model
`default_nettype wire

// ### verilog/wdat_cnt_if.sv
// Link between the watchdog control logic and its counter chain
`timescale 1ns/1ps
`default_nettype none
interface wdat_cnt_if;
  logic                  run;
  logic                  pause;
  logic                  clear;
  wdat_pkg::wdat_period_t period;
  logic                  overflow;
  wdat_pkg::wdat_bin_t    bin_cnt;

  modport ctl (output run, output pause, output clear, output period, input overflow, input bin_cnt);
  modport cnt (input run, input pause, input clear, input period, output overflow, output bin_cnt);
endinterface
`default_nettype wire

// ### verilog/wdat_counter.sv
// Internal divider and two-stage binary counter of the watchdog
`timescale 1ns/1ps
`default_nettype none
`include "wdat_map.svh"
module wdat_counter #(
  parameter int DIV_W = `WDAT_DIV_W
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  // Control side
  wdat_cnt_if.cnt   cnt
);
  logic [DIV_W-1:0]    div_q;
  logic [DIV_W-1:0]    low_mask;
  logic                tick;
  wdat_pkg::wdat_bin_t bin_q;
  logic                ovf_q;

  localparam logic [DIV_W-1:0] DIV_ONE = {{(DIV_W-1){1'b0}}, 1'b1};

  // Tap moves two bits down per period code
  always_comb begin
    low_mask = {DIV_W{1'b1}} >> {cnt.period, 1'b0};
    tick     = &(div_q | ~low_mask);
  end

  // Divider is never cleared by the clear code
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      div_q <= '0;
    end else if (!cnt.pause) begin
      div_q <= div_q + DIV_ONE;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      bin_q <= 2'h0;
    end else if (!cnt.run || cnt.clear) begin
      bin_q <= 2'h0;
    end else if (!cnt.pause && tick) begin
      bin_q <= bin_q + 2'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ovf_q <= 1'b0;
    end else begin
      ovf_q <= cnt.run && !cnt.clear && !cnt.pause && tick && (bin_q == 2'h3);
    end
  end

  assign cnt.overflow = ovf_q;
  assign cnt.bin_cnt  = bin_q;

  a_disabled_clear: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !cnt.run |=> (bin_q == 2'h0))
    else $error("binary counter not cleared while disabled");
  a_clear_bin_only: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (cnt.clear && !cnt.pause) |=> (bin_q == 2'h0) && (div_q == $past(div_q) + DIV_ONE))
    else $error("clear code touched divider or missed counter");
  a_pause_holds: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (cnt.pause && cnt.run && !cnt.clear) |=> $stable(div_q) && $stable(bin_q))
    else $error("counter moved in low power mode");
endmodule // wdat_counter
`default_nettype wire

// ### verilog/wdat_map.svh
// Offsets, field positions, reset values and timing counts of the watchdog and address trap
`ifndef WDAT_MAP_SVH
`define WDAT_MAP_SVH

// Register byte offsets on APB
`define WDAT_ADDR_W          12
`define WDAT_OFF_CTRL_ONE    12'h000
`define WDAT_OFF_COMMAND     12'h004
`define WDAT_OFF_STATUS      12'h008

// Control register one fields
`define WDAT_BIT_OVF_ACT     0
`define WDAT_BIT_PERIOD_LO   1
`define WDAT_BIT_PERIOD_HI   2
`define WDAT_BIT_ENABLE      3
`define WDAT_BIT_TRAP_ACT    4
`define WDAT_BIT_RAM_TRAP    5
`define WDAT_RST_CTRL_ONE    8'h39

// Command codes
`define WDAT_CODE_CLEAR      8'h4E
`define WDAT_CODE_DISABLE    8'hB1
`define WDAT_CODE_RAM_COMMIT 8'hD2

// Status register fields
`define WDAT_ST_RUNNING      0
`define WDAT_ST_BIN_LO       1
`define WDAT_ST_BIN_HI       2
`define WDAT_ST_RAM_EFF      3
`define WDAT_ST_RST_HOLD     4
`define WDAT_ST_OVF_ACT      5
`define WDAT_ST_TRAP_ACT     6

// Fetch address areas
`define WDAT_SFR_BASE        16'h0000
`define WDAT_SFR_LAST        16'h003F
`define WDAT_RAM_BASE        16'h0040
`define WDAT_RAM_LAST        16'h083F

// Timing
`define WDAT_CLK_HZ          20000000
`define WDAT_FC_HZ           20000000
`define WDAT_DIV_W           23
`define WDAT_RESET_TIME_FC   24
`define WDAT_RESET_CYCLES    ((`WDAT_RESET_TIME_FC * `WDAT_CLK_HZ) / `WDAT_FC_HZ)

`endif

// ### verilog/wdat_pkg.sv
// Types shared by the watchdog and address trap modules
package wdat_pkg;
  typedef logic [1:0] wdat_period_t;
  typedef logic [1:0] wdat_bin_t;
  typedef enum logic {
    WDAT_RS_IDLE,
    WDAT_RS_HOLD
  } wdat_rst_state_t;
endpackage

// ### verilog/wdat_top.sv
// Watchdog timer with address trap monitor and APB register slave
//
// How it works
// - Enable bit resets to one so the watchdog runs after reset.
// - Binary counters are held cleared while the watchdog is disabled.
// - Overflow with action bit zero raises the overflow interrupt request.
// - Overflow interrupt request is non-maskable, never gated by the mask flag.
// - Every overflow raises a new request even while another is in service.
// - Overflow with action bit one requests reset and drives reset pin low.
// - Two-bit period field picks four periods, code 00 longest.
// - New RAM-trap select takes effect only on the commit code.
// - Fetch from the register area always traps.
// - Trap with action bit zero raises the non-maskable fetch-trap interrupt.
// - Every trap raises a new request even while another is in service.
// - Trap with action bit one requests reset and drives reset pin low.
// - Trap reset in low-speed mode one restarts the fast oscillator.
// - Clear code clears only the binary counter, not the divider.
// - Once cleared, the overflow action bit cannot be set again.
// - Counter pauses in stop, idle and sleep and then continues.
//
// Register access over APB and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "wdat_map.svh"
module wdat_top #(
  parameter int DIV_W = `WDAT_DIV_W
) (
  // Clock and reset
  input  wire logic                     clk_i,
  input  wire logic                     rst_n_i,
  // APB slave
  input  wire logic [`WDAT_ADDR_W-1:0]  paddr_i,
  input  wire logic                     psel_i,
  input  wire logic                     penable_i,
  input  wire logic                     pwrite_i,
  input  wire logic [31:0]              pwdata_i,
  output logic      [31:0]              prdata_o,
  output logic                          pready_o,
  output logic                          pslverr_o,
  // CPU core
  input  wire logic                     fetch_valid_i,
  input  wire logic [15:0]              fetch_addr_i,
  input  wire logic                     power_pause_i,
  input  wire logic                     low_speed_mode_one_i,
  // Events
  output logic                          wd_overflow_irq_o,
  output logic                          fetch_trap_irq_o,
  output logic                          sys_reset_req_o,
  output logic                          reset_pin_n_o,
  output logic                          osc_restart_o
);
  localparam logic [4:0] RESET_LEN = 5'(`WDAT_RESET_CYCLES);
  localparam logic [7:0] RST_CTRL  = `WDAT_RST_CTRL_ONE;

  wdat_cnt_if cnt_if ();

  logic                        pready_q;
  logic [31:0]                 prdata_q;
  logic                        pslverr_q;
  logic                        access;
  logic                        wr_en;
  logic                        mapped;
  logic                        ctrl_wr;
  logic                        cmd_wr;
  logic [7:0]                  wbyte;
  logic                        wd_enable_bit_q;
  wdat_pkg::wdat_period_t      detect_period_select_q;
  logic                        overflow_action_select_q;
  logic                        trap_action_select_q;
  logic                        ram_trap_select_q;
  logic                        ram_trap_eff_q;
  logic                        running_q;
  logic                        clear_q;
  logic                        in_sfr;
  logic                        in_ram;
  logic                        trap_hit;
  logic                        ovf_irq_q;
  logic                        trap_irq_q;
  logic                        reset_ev;
  wdat_pkg::wdat_rst_state_t   rs_q;
  logic [4:0]                  rst_cnt_q;
  logic                        pin_n_q;
  logic                        req_q;
  logic                        osc_q;

  // Bus decode
  always_comb begin
    access  = psel_i && penable_i && pready_q;
    wr_en   = access && pwrite_i;
    wbyte   = pwdata_i[7:0];
    mapped  = (paddr_i == `WDAT_OFF_CTRL_ONE) || (paddr_i == `WDAT_OFF_COMMAND) ||
              (paddr_i == `WDAT_OFF_STATUS);
    ctrl_wr = wr_en && (paddr_i == `WDAT_OFF_CTRL_ONE);
    cmd_wr  = wr_en && (paddr_i == `WDAT_OFF_COMMAND);
  end

  // Zero-wait answer: ready registered at the end of the setup cycle, high in the first access cycle
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      pready_q <= 1'b0;
    end else begin
      pready_q <= psel_i && !penable_i && !pready_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      pslverr_q <= 1'b0;
    end else begin
      pslverr_q <= psel_i && !penable_i && !pready_q && !mapped;
    end
  end

  // Control one and command read as zero
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      prdata_q <= 32'h0000_0000;
    end else if (psel_i && !penable_i && !pready_q) begin
      prdata_q <= 32'h0000_0000;
      if (!pwrite_i && paddr_i == `WDAT_OFF_STATUS) begin
        prdata_q[`WDAT_ST_RUNNING]                   <= running_q;
        prdata_q[`WDAT_ST_BIN_HI:`WDAT_ST_BIN_LO]    <= cnt_if.bin_cnt;
        prdata_q[`WDAT_ST_RAM_EFF]                   <= ram_trap_eff_q;
        prdata_q[`WDAT_ST_RST_HOLD]                  <= (rs_q == wdat_pkg::WDAT_RS_HOLD);
        prdata_q[`WDAT_ST_OVF_ACT]                   <= overflow_action_select_q;
        prdata_q[`WDAT_ST_TRAP_ACT]                  <= trap_action_select_q;
      end
    end
  end

  // Control register one
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wd_enable_bit_q        <= RST_CTRL[`WDAT_BIT_ENABLE];
      detect_period_select_q <= 2'h0;
      trap_action_select_q   <= 1'b1;
      ram_trap_select_q      <= 1'b1;
    end else if (ctrl_wr) begin
      wd_enable_bit_q        <= wbyte[`WDAT_BIT_ENABLE];
      detect_period_select_q <= wbyte[`WDAT_BIT_PERIOD_HI:`WDAT_BIT_PERIOD_LO];
      trap_action_select_q   <= wbyte[`WDAT_BIT_TRAP_ACT];
      ram_trap_select_q      <= wbyte[`WDAT_BIT_RAM_TRAP];
    end
  end

  // Action bit may only fall
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      overflow_action_select_q <= 1'b1;
    end else if (ctrl_wr) begin
      overflow_action_select_q <= overflow_action_select_q & wbyte[`WDAT_BIT_OVF_ACT];
    end
  end

  // Selected RAM trapping applied by commit code
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ram_trap_eff_q <= 1'b1;
    end else if (cmd_wr && wbyte == `WDAT_CODE_RAM_COMMIT) begin
      ram_trap_eff_q <= ram_trap_select_q;
    end
  end

  // Run state: enable acts at once, disable needs code with bit cleared
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      running_q <= 1'b1;
    end else if (ctrl_wr && wbyte[`WDAT_BIT_ENABLE]) begin
      running_q <= 1'b1;
    end else if (cmd_wr && wbyte == `WDAT_CODE_DISABLE && !wd_enable_bit_q) begin
      running_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      clear_q <= 1'b0;
    end else begin
      clear_q <= cmd_wr && wbyte == `WDAT_CODE_CLEAR;
    end
  end

  assign cnt_if.run    = running_q;
  assign cnt_if.pause  = power_pause_i;
  assign cnt_if.clear  = clear_q;
  assign cnt_if.period = detect_period_select_q;

  wdat_counter #(
    .DIV_W (DIV_W)
  ) u_counter (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .cnt     (cnt_if.cnt)
  );

  // Address trap detection
  always_comb begin
    // Register area starts at address zero
    in_sfr   = (fetch_addr_i <= `WDAT_SFR_LAST);
    in_ram   = (fetch_addr_i >= `WDAT_RAM_BASE) && (fetch_addr_i <= `WDAT_RAM_LAST);
    trap_hit = fetch_valid_i && (in_sfr || (ram_trap_eff_q && in_ram));
    reset_ev = (cnt_if.overflow && overflow_action_select_q) || (trap_hit && trap_action_select_q);
  end

  // Requests ignore the mask flag and any interrupt in service
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ovf_irq_q <= 1'b0;
    end else begin
      ovf_irq_q <= cnt_if.overflow && !overflow_action_select_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      trap_irq_q <= 1'b0;
    end else begin
      trap_irq_q <= trap_hit && !trap_action_select_q;
    end
  end

  // Reset pulse sequencer
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rs_q      <= wdat_pkg::WDAT_RS_IDLE;
      rst_cnt_q <= 5'h00;
      pin_n_q   <= 1'b1;
    end else begin
      unique case (rs_q)
        wdat_pkg::WDAT_RS_IDLE: begin
          if (reset_ev) begin
            rs_q      <= wdat_pkg::WDAT_RS_HOLD;
            rst_cnt_q <= RESET_LEN - 5'h01;
            pin_n_q   <= 1'b0;
          end
        end
        wdat_pkg::WDAT_RS_HOLD: begin
          if (rst_cnt_q == 5'h00) begin
            rs_q    <= wdat_pkg::WDAT_RS_IDLE;
            pin_n_q <= 1'b1;
          end else begin
            rst_cnt_q <= rst_cnt_q - 5'h01;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      req_q <= 1'b0;
      osc_q <= 1'b0;
    end else begin
      req_q <= reset_ev && rs_q == wdat_pkg::WDAT_RS_IDLE;
      osc_q <= reset_ev && rs_q == wdat_pkg::WDAT_RS_IDLE && trap_hit && trap_action_select_q &&
               low_speed_mode_one_i;
    end
  end

  assign prdata_o          = prdata_q;
  assign pready_o          = pready_q;
  assign pslverr_o         = pslverr_q;
  assign wd_overflow_irq_o = ovf_irq_q;
  assign fetch_trap_irq_o  = trap_irq_q;
  assign sys_reset_req_o   = req_q;
  assign reset_pin_n_o     = pin_n_q;
  assign osc_restart_o     = osc_q;

  // Helper: length of the current low phase on the reset pin
  logic [5:0] low_len_q;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || pin_n_q) begin
      low_len_q <= 6'h00;
    end else begin
      low_len_q <= low_len_q + 6'h01;
    end
  end

  sequence s_reset_low;
    !reset_pin_n_o [*8];
  endsequence

  a_enable_after_rst: assert property (@(posedge clk_i)
    $rose(rst_n_i) |-> running_q && wd_enable_bit_q)
    else $error("watchdog not enabled after reset");
  a_disable_order: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $fell(running_q) |-> $past(cmd_wr && wbyte == `WDAT_CODE_DISABLE && !wd_enable_bit_q))
    else $error("watchdog stopped without disable code");
  a_ovf_irq_req: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (cnt_if.overflow && !overflow_action_select_q) |=> wd_overflow_irq_o &&
      (sys_reset_req_o == $past(trap_hit && trap_action_select_q && rs_q == wdat_pkg::WDAT_RS_IDLE)))
    else $error("overflow interrupt missing");
  a_ovf_reset_pin: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (cnt_if.overflow && overflow_action_select_q && rs_q == wdat_pkg::WDAT_RS_IDLE) |=>
      sys_reset_req_o ##0 s_reset_low)
    else $error("overflow reset not driven");
  a_reset_length: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    low_len_q <= 6'(`WDAT_RESET_CYCLES))
    else $error("reset pin held low too long");
  a_sfr_trap: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (fetch_valid_i && in_sfr && !trap_action_select_q) |=> fetch_trap_irq_o)
    else $error("register area fetch did not trap");
  a_ram_trap_gate: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (fetch_valid_i && in_ram && !ram_trap_eff_q) |=> !fetch_trap_irq_o)
    else $error("RAM fetch trapped while not selected");
  a_trap_reset_pin: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (trap_hit && trap_action_select_q && rs_q == wdat_pkg::WDAT_RS_IDLE) |=> s_reset_low)
    else $error("trap reset not driven");
  a_osc_restart: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    osc_restart_o |-> sys_reset_req_o && $past(low_speed_mode_one_i))
    else $error("oscillator restart without slow trap reset");
  a_ram_sel_commit: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !(cmd_wr && wbyte == `WDAT_CODE_RAM_COMMIT) |=> $stable(ram_trap_eff_q))
    else $error("RAM trap select applied without commit");
  a_action_once: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !overflow_action_select_q |=> !overflow_action_select_q)
    else $error("overflow action set again");
endmodule // wdat_top
`default_nettype wire
